// File: src/rx_port_stream_config.v
// Overview of operation
// - each port has own registers, selected copy
// - first-frame-start wait needs frame count one
// - CSI mode: frame-start wait blocks packets until start
// - CSI mode: checksum-error packets pass only when enabled
// - CSI mode: ECC-error packets pass only when enabled
// - CSI mode: bit three passes length errors
// - RAW mode: bit three drops short line
// - cable bit: zero twisted pair, one coax
// - cable and format reset from strap pins
// - format field: CSI, RAW12x2, RAW10 encodings
// - four slot selectors, reset constant zero
// - selector codes: zero, one, sync, reserved
// - top bit clear selects local GPIO pin
// - RAW10 mode tags with ten-bit channel
// - RAW channel tags reset to port number
// - RAW10 mode uses ten-bit type code
// - RAW12 mode tags with twelve-bit channel
// - RAW12 mode uses twelve-bit type code
// - CSI mode remaps incoming virtual channel
// - remap table four entries, identity reset
`timescale 1ns/1ps
`include "rx_port_stream_config_regs.vh"

module rx_port_stream_config #(
  parameter PORTS = 2,
  parameter PW    = 1,
  parameter DW    = 8
) (
  input  wire                 mclk,
  input  wire                 sys_rst,
  input  wire                 ce,
  input  wire                 powerDownBar,
  input  wire [2:0]           strapMode,
  input  wire [7:0]           regAddr,
  input  wire [7:0]           regWrData,
  input  wire                 regWr,
  input  wire                 regRd,
  output reg  [7:0]           regRdData_ff,
  input  wire [7:0]           localGpio,
  input  wire                 cameraSyncPulse,
  output reg  [PORTS*4-1:0]   returnSlots_ff,
  output reg  [PORTS-1:0]     cableCoax_ff,
  input  wire                 inValid,
  input  wire                 inStart,
  input  wire                 inEnd,
  input  wire [PW-1:0]        inPort,
  input  wire [DW-1:0]        inData,
  input  wire [1:0]           inVc,
  input  wire [5:0]           inDt,
  input  wire                 inFrameStart,
  input  wire [15:0]          inFrameNum,
  input  wire                 inCksumErr,
  input  wire                 inEccErr,
  input  wire                 inLenErr,
  input  wire                 inShortLine,
  output reg                  outValid_ff,
  output reg                  outStart_ff,
  output reg                  outEnd_ff,
  output reg  [PW-1:0]        outPort_ff,
  output reg  [DW-1:0]        outData_ff,
  output reg  [1:0]           outVc_ff,
  output reg  [5:0]           outDt_ff
);

  reg [7:0]       portSelect_ff;
  reg [7:0]       options_ff   [0:PORTS-1];
  reg [7:0]       pinSelLo_ff  [0:PORTS-1];
  reg [7:0]       pinSelHi_ff  [0:PORTS-1];
  reg [7:0]       tenTag_ff    [0:PORTS-1];
  reg [7:0]       twelveTag_ff [0:PORTS-1];
  reg [7:0]       remap_ff     [0:PORTS-1];
  reg [PORTS-1:0] waiting_ff;
  reg             pdbPrev_ff;
  reg             keep_ff;
  integer         p;
  integer         k;
  integer         g;

  // RAW channel tag resets to the port's own number
  function [1:0] portVc;
    input integer idx;
    begin
      portVc = idx[1:0];
    end
  endfunction

  function slotLevel;
    input [3:0] sel;
    input [7:0] gpio;
    input       sync;
    begin
      if (!sel[3])
        slotLevel = gpio[sel[2:0]];
      else if (sel == `SLOT_ONE)
        slotLevel = 1'b1;
      else if (sel == `SLOT_SYNC)
        slotLevel = sync;
      else
        slotLevel = 1'b0;
    end
  endfunction

  // entry n of the table replaces incoming channel n
  function [1:0] remapVc;
    input [7:0] map;
    input [1:0] vc;
    begin
      case (vc)
        2'h0: remapVc = map[1:0];
        2'h1: remapVc = map[3:2];
        2'h2: remapVc = map[5:4];
        default: remapVc = map[7:6];
      endcase
    end
  endfunction

  // a write reaches a port copy only while its select bit is set
  function portHit;
    input [7:0]   sel;
    input integer idx;
    input         wr;
    begin
      portHit = wr & sel[`PSEL_WR_LSB + idx];
    end
  endfunction

  // detector resets low, so a pin already high at release still loads the strap
  wire       pdbRise = powerDownBar & ~pdbPrev_ff;
  wire [7:0] inOpt   = options_ff[inPort];
  wire [1:0] inMode  = inOpt[`OPT_MODE_MSB:`OPT_MODE_LSB];
  wire       inCsi   = (inMode == `MODE_CSI);
  wire       inTen   = (inMode == `MODE_TEN_100);
  wire       holdAny = inOpt[`OPT_FIRST_FS_BIT] | inOpt[`OPT_FS_BIT];
  // with the first-start bit set only a frame start counting one opens the gate
  wire       fsOpens = inFrameStart &
                       (~inOpt[`OPT_FIRST_FS_BIT] | (inFrameNum == 16'h0001));
  // the opening frame-start packet itself passes the gate
  wire       gated   = inCsi & holdAny & waiting_ff[inPort] & ~fsOpens;
  wire       csiBad  = inCsi & ((inCksumErr & ~inOpt[`OPT_CKSUM_BIT]) |
                                (inEccErr & ~inOpt[`OPT_ECC_BIT]) |
                                (inLenErr & ~inOpt[`OPT_LEN_BIT]));
  wire       rawBad  = ~inCsi & inShortLine & inOpt[`OPT_LEN_BIT];
  // error flags must come with the head beat; nothing is buffered to wait for them
  wire       keepNow = ~gated & ~csiBad & ~rawBad;
  wire       beatOk  = inStart ? keepNow : keep_ff;

  // RAW streams carry no header, so the port supplies channel and type
  wire [1:0] rawVc   = inTen ? tenTag_ff[inPort][`TAG_VC_MSB:`TAG_VC_LSB]
                             : twelveTag_ff[inPort][`TAG_VC_MSB:`TAG_VC_LSB];
  wire [5:0] rawDt   = inTen ? tenTag_ff[inPort][`TAG_DT_MSB:`TAG_DT_LSB]
                             : twelveTag_ff[inPort][`TAG_DT_MSB:`TAG_DT_LSB];
  wire [1:0] nxt_vc  = inCsi ? remapVc(remap_ff[inPort], inVc) : rawVc;
  wire [5:0] nxt_dt  = inCsi ? inDt : rawDt;

  // writes may fan out to several ports, reads see one port at a time
  wire [PW-1:0] rdPort = portSelect_ff[`PSEL_RD_BIT +: PW];

  // configuration registers, one copy per port
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      portSelect_ff <= `PSEL_RESET;
      pdbPrev_ff    <= 1'b0;
      for (p = 0; p < PORTS; p = p + 1)
      begin
        options_ff[p]   <= {`OPT_RESET_UPPER, 3'h0};
        pinSelLo_ff[p]  <= {`SLOT_RESET, `SLOT_RESET};
        pinSelHi_ff[p]  <= {`SLOT_RESET, `SLOT_RESET};
        tenTag_ff[p]    <= {portVc(p), `TEN_DT_RESET};
        twelveTag_ff[p] <= {portVc(p), `TWELVE_DT_RESET};
        remap_ff[p]     <= `REMAP_RESET;
      end
    end
    else if (ce)
    begin
      pdbPrev_ff <= powerDownBar;
      for (p = 0; p < PORTS; p = p + 1)
      begin
        // strap is caught by the clock once power-down is released
        if (pdbRise)
          options_ff[p][2:0] <= strapMode;
        if (portHit(portSelect_ff, p, regWr))
        begin
          if (regAddr == `ADDR_RX_PORT_OPTIONS)
            options_ff[p] <= regWrData;
          else if (regAddr == `ADDR_PIN_SELECT_LO)
            pinSelLo_ff[p] <= regWrData;
          else if (regAddr == `ADDR_PIN_SELECT_HI)
            pinSelHi_ff[p] <= regWrData;
          else if (regAddr == `ADDR_TEN_BIT_STREAM_TAG)
            tenTag_ff[p] <= regWrData;
          else if (regAddr == `ADDR_TWELVE_BIT_STREAM_TAG)
            twelveTag_ff[p] <= regWrData;
          else if (regAddr == `ADDR_CHANNEL_ID_REMAP)
            remap_ff[p] <= regWrData;
        end
      end
      if (regWr && regAddr == `ADDR_PORT_SELECT)
        portSelect_ff <= regWrData;
    end
  end

  // read answer one cycle after the strobe; unmapped offsets read zero
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData_ff <= 8'h00;
    else if (ce && regRd)
    begin
      if (regAddr == `ADDR_PORT_SELECT)
        regRdData_ff <= portSelect_ff;
      else if (regAddr == `ADDR_RX_PORT_OPTIONS)
        regRdData_ff <= options_ff[rdPort];
      else if (regAddr == `ADDR_PIN_SELECT_LO)
        regRdData_ff <= pinSelLo_ff[rdPort];
      else if (regAddr == `ADDR_PIN_SELECT_HI)
        regRdData_ff <= pinSelHi_ff[rdPort];
      else if (regAddr == `ADDR_TEN_BIT_STREAM_TAG)
        regRdData_ff <= tenTag_ff[rdPort];
      else if (regAddr == `ADDR_TWELVE_BIT_STREAM_TAG)
        regRdData_ff <= twelveTag_ff[rdPort];
      else if (regAddr == `ADDR_CHANNEL_ID_REMAP)
        regRdData_ff <= remap_ff[rdPort];
      else
        regRdData_ff <= 8'h00;
    end
  end

  // back-channel slot levels and cable mode, per port
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      returnSlots_ff <= {PORTS*4{1'b0}};
      cableCoax_ff   <= {PORTS{1'b0}};
    end
    else if (ce)
    begin
      for (k = 0; k < PORTS; k = k + 1)
      begin
        returnSlots_ff[4*k]   <= slotLevel(pinSelLo_ff[k][3:0], localGpio, cameraSyncPulse);
        returnSlots_ff[4*k+1] <= slotLevel(pinSelLo_ff[k][7:4], localGpio, cameraSyncPulse);
        returnSlots_ff[4*k+2] <= slotLevel(pinSelHi_ff[k][3:0], localGpio, cameraSyncPulse);
        returnSlots_ff[4*k+3] <= slotLevel(pinSelHi_ff[k][7:4], localGpio, cameraSyncPulse);
        cableCoax_ff[k]       <= options_ff[k][`OPT_COAX_BIT];
      end
    end
  end

  // frame-start gate: armed at reset and when a hold bit is written set
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      waiting_ff <= {PORTS{1'b1}};
    else if (ce)
    begin
      for (g = 0; g < PORTS; g = g + 1)
      begin
        // re-arming by a write wins over a frame start in the same cycle
        if (portHit(portSelect_ff, g, regWr) &&
            regAddr == `ADDR_RX_PORT_OPTIONS &&
            (regWrData[`OPT_FIRST_FS_BIT] || regWrData[`OPT_FS_BIT]))
          waiting_ff[g] <= 1'b1;
        else if (inValid && inStart && inPort == g[PW-1:0] && inCsi && fsOpens)
          waiting_ff[g] <= 1'b0;
      end
    end
  end

  // packet path: verdict taken on the first beat and held to the last
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      keep_ff     <= 1'b0;
      outValid_ff <= 1'b0;
      outStart_ff <= 1'b0;
      outEnd_ff   <= 1'b0;
      outPort_ff  <= {PW{1'b0}};
      outData_ff  <= {DW{1'b0}};
      outVc_ff    <= 2'h0;
      outDt_ff    <= 6'h00;
    end
    else if (ce)
    begin
      outValid_ff <= inValid & beatOk;
      outStart_ff <= inValid & beatOk & inStart;
      outEnd_ff   <= inValid & beatOk & inEnd;
      if (inValid && inStart)
      begin
        keep_ff    <= keepNow;
        outVc_ff   <= nxt_vc;
        outDt_ff   <= nxt_dt;
        outPort_ff <= inPort;
      end
      if (inValid)
        outData_ff <= inData;
    end
  end

endmodule // rx_port_stream_config

// File: src/rx_port_stream_config_regs.vh
`ifndef RX_PORT_STREAM_CONFIG_REGS_VH
`define RX_PORT_STREAM_CONFIG_REGS_VH

// register offsets
`define ADDR_PORT_SELECT           8'h4C
`define ADDR_RX_PORT_OPTIONS       8'h6D
`define ADDR_PIN_SELECT_LO         8'h6E
`define ADDR_PIN_SELECT_HI         8'h6F
`define ADDR_TEN_BIT_STREAM_TAG    8'h70
`define ADDR_TWELVE_BIT_STREAM_TAG 8'h71
`define ADDR_CHANNEL_ID_REMAP      8'h72

// port select fields
`define PSEL_WR_LSB                0
`define PSEL_RD_BIT                4
`define PSEL_RESET                 8'h01

// rx_port_options fields
`define OPT_FIRST_FS_BIT           7
`define OPT_FS_BIT                 6
`define OPT_CKSUM_BIT              5
`define OPT_ECC_BIT                4
`define OPT_LEN_BIT                3
`define OPT_COAX_BIT               2
`define OPT_MODE_MSB               1
`define OPT_MODE_LSB               0
`define OPT_RESET_UPPER            5'h0F

// link input formats
`define MODE_CSI                   2'h0
`define MODE_TWELVE_50             2'h1
`define MODE_TWELVE_75             2'h2
`define MODE_TEN_100               2'h3

// return slot source codes
`define SLOT_ZERO                  4'h8
`define SLOT_ONE                   4'h9
`define SLOT_SYNC                  4'hA
`define SLOT_RESET                 4'h8

// stream tag fields and resets
`define TAG_VC_MSB                 7
`define TAG_VC_LSB                 6
`define TAG_DT_MSB                 5
`define TAG_DT_LSB                 0
`define TEN_DT_RESET               6'h2B
`define TWELVE_DT_RESET            6'h2C
`define REMAP_RESET                8'hE4

`endif

// File: bench/rx_port_stream_config_asserts.sv
`timescale 1ns/1ps
module rx_port_stream_config_asserts #(
  parameter PORTS = 2,
  parameter DW    = 8
) (
  input wire             mclk,
  input wire             sys_rst,
  input wire             powerDownBar,
  input wire [2:0]       strapMode,
  input wire [7:0]       regAddr,
  input wire             regRd,
  input wire [7:0]       regRdData_ff,
  input wire [PORTS-1:0] cableCoax_ff,
  input wire             inValid,
  input wire             inStart,
  input wire             inEnd,
  input wire [DW-1:0]    inData,
  input wire             outValid_ff,
  input wire             outStart_ff,
  input wire             outEnd_ff,
  input wire [DW-1:0]    outData_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence s_strapSeen;
    $rose(powerDownBar);
  endsequence
  sequence s_coaxLoaded;
    ##[1:2] cableCoax_ff[0] == strapMode[2];
  endsequence
  property p_strapLoad;
    s_strapSeen |-> s_coaxLoaded;
  endproperty
  property p_beatFollow;
    outValid_ff |-> $past(inValid);
  endproperty
  property p_startFollow;
    outStart_ff |-> $past(inValid && inStart);
  endproperty
  property p_endFollow;
    outEnd_ff |-> $past(inValid && inEnd);
  endproperty
  property p_dataFollow;
    outValid_ff |-> outData_ff == $past(inData);
  endproperty
  // a tail beat without its head would mean a partly dropped packet
  property p_noPartial;
    outValid_ff && !outStart_ff |-> $past(outValid_ff);
  endproperty
  property p_rdUnmapped;
    regRd && regAddr == 8'h10 |=> regRdData_ff == 8'h00;
  endproperty
  property p_rdHold;
    !regRd |=> $stable(regRdData_ff);
  endproperty
  a_strapLoad: assert property (p_strapLoad) else $error("coax bit missed strap");
  a_beatFollow: assert property (p_beatFollow) else $error("beat without input");
  a_startFollow: assert property (p_startFollow) else $error("bad start beat");
  a_endFollow: assert property (p_endFollow) else $error("bad end beat");
  a_dataFollow: assert property (p_dataFollow) else $error("beat data changed");
  a_noPartial: assert property (p_noPartial) else $error("partial packet out");
  a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
endmodule // rx_port_stream_config_asserts

bind rx_port_stream_config rx_port_stream_config_asserts #(.PORTS(PORTS), .DW(DW)) u_asserts (
  .mclk(mclk), .sys_rst(sys_rst), .powerDownBar(powerDownBar), .strapMode(strapMode),
  .regAddr(regAddr), .regRd(regRd), .regRdData_ff(regRdData_ff), .cableCoax_ff(cableCoax_ff),
  .inValid(inValid), .inStart(inStart), .inEnd(inEnd), .inData(inData),
  .outValid_ff(outValid_ff), .outStart_ff(outStart_ff), .outEnd_ff(outEnd_ff),
  .outData_ff(outData_ff));

// File: bench/serializer_model.sv
`timescale 1ns/1ps
module serializer_model (
  input  wire        mclk,
  output reg         inValid,
  output reg         inStart,
  output reg         inEnd,
  output reg         inPort,
  output reg  [7:0]  inData,
  output reg  [1:0]  inVc,
  output reg  [5:0]  inDt,
  output reg         inFrameStart,
  output reg  [15:0] inFrameNum,
  output reg  [3:0]  errs
);
  initial
  begin
    {inValid, inStart, inEnd, inPort, inData, inVc, inDt, inFrameStart, inFrameNum, errs} = 0;
  end
  // header fields scramble after the start beat, so a late sample shows up
  task send(input pt, input [1:0] vc, input [5:0] dt, input fs, input [15:0] fn, input [3:0] e);
    @(posedge mclk) #1;
    inPort = pt;
    {inValid, inStart, inVc, inDt, inFrameStart, inFrameNum, errs} = {2'b11, vc, dt, fs, fn, e};
    inData = {dt, vc};
    @(posedge mclk) #1;
    {inStart, inEnd, inVc, inDt, inFrameStart, inFrameNum, errs} = ~{1'b1, 1'b0, vc, dt, fs, fn, e};
    inData = ~inData;
    @(posedge mclk) #1;
    {inValid, inEnd} = 2'b00;
    inData = ~inData;
  endtask
endmodule // serializer_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, sys_rst = 1, ce = 1, powerDownBar = 0, regWr = 0, regRd = 0, cameraSyncPulse = 0;
  reg pktPort = 0;
  reg [2:0] strapMode = 3'h4;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00, localGpio = 8'h00;
  wire inValid, inStart, inEnd, inPort, inFrameStart, outValid_ff, outStart_ff, outEnd_ff;
  wire outPort_ff;
  wire [7:0] inData, regRdData_ff, returnSlots_ff, outData_ff;
  wire [1:0] inVc, outVc_ff, cableCoax_ff;
  wire [5:0] inDt, outDt_ff;
  wire [15:0] inFrameNum;
  wire [3:0] errs;
  integer mismatches = 0, compares = 0, starts = 0, n;
  reg [7:0] gotVc, gotDt, gotPort;
  always #12.5 mclk = ~mclk;
  serializer_model u_serializer_model (.mclk(mclk), .inValid(inValid), .inStart(inStart),
    .inEnd(inEnd), .inPort(inPort), .inData(inData), .inVc(inVc), .inDt(inDt),
    .inFrameStart(inFrameStart), .inFrameNum(inFrameNum), .errs(errs));
  rx_port_stream_config u_rx_port_stream_config (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .powerDownBar(powerDownBar),
    .strapMode(strapMode), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData_ff(regRdData_ff), .localGpio(localGpio),
    .cameraSyncPulse(cameraSyncPulse), .returnSlots_ff(returnSlots_ff),
    .cableCoax_ff(cableCoax_ff), .inValid(inValid), .inStart(inStart), .inEnd(inEnd),
    .inPort(inPort), .inData(inData), .inVc(inVc), .inDt(inDt), .inFrameStart(inFrameStart),
    .inFrameNum(inFrameNum), .inCksumErr(errs[3]), .inEccErr(errs[2]), .inLenErr(errs[1]),
    .inShortLine(errs[0]), .outValid_ff(outValid_ff), .outStart_ff(outStart_ff),
    .outEnd_ff(outEnd_ff), .outPort_ff(outPort_ff), .outData_ff(outData_ff),
    .outVc_ff(outVc_ff), .outDt_ff(outDt_ff));
  always @(posedge mclk)
    if (outValid_ff === 1'b1 && outStart_ff === 1'b1)
    begin
      starts = starts + 1;
      gotVc = outVc_ff;
      gotDt = outDt_ff;
      gotPort = outPort_ff;
    end
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk) #1;
    {regAddr, regWrData, regWr} = {a, d, 1'b1};
    @(posedge mclk) #1;
    regWr = 0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(posedge mclk) #1;
    {regAddr, regRd} = {a, 1'b1};
    @(posedge mclk) #1;
    regRd = 0;
    chk(regRdData_ff, exp);
  endtask
  task pkt(input keep, input [1:0] vc, input [5:0] dt, input fs, input [15:0] fn,
    input [3:0] e, input [1:0] xVc, input [5:0] xDt);
    n = starts;
    u_serializer_model.send(pktPort, vc, dt, fs, fn, e);
    @(posedge mclk) #1;
    chk(starts - n, {7'h00, keep});
    if (keep)
    begin
      chk(gotVc, {6'h00, xVc});
      chk(gotDt, {2'h0, xDt});
      chk(gotPort, {7'h00, pktPort});
    end
  endtask
  task t_port1;
    pktPort = 1;
    pkt(0, 2'h0, 6'h12, 0, 16'h0000, 4'h0, 2'h0, 6'h12);
    pkt(1, 2'h0, 6'h00, 1, 16'h0003, 4'h0, 2'h3, 6'h00);
    pkt(1, 2'h1, 6'h12, 0, 16'h0000, 4'h0, 2'h2, 6'h12);
    pktPort = 0;
  endtask
  task t_freeze;
    ce = 0;
    wr(8'h72, 8'h55);
    ce = 1;
    rd(8'h72, 8'hE4);
  endtask
  task t_defaults;
    rd(8'h6D, 8'h7C);
    rd(8'h6E, 8'h88);
    rd(8'h6F, 8'h88);
    rd(8'h70, 8'h2B);
    rd(8'h71, 8'h2C);
    rd(8'h72, 8'hE4);
    rd(8'h10, 8'h00);
    wr(8'h4C, 8'h12);
    rd(8'h70, 8'h6B);
    rd(8'h71, 8'h6C);
    wr(8'h72, 8'h1B);
    rd(8'h72, 8'h1B);
    wr(8'h4C, 8'h01);
    rd(8'h72, 8'hE4);
  endtask
  task t_gate;
    pkt(0, 2'h1, 6'h12, 0, 16'h0000, 4'h0, 2'h0, 6'h00);
    pkt(1, 2'h0, 6'h00, 1, 16'h0005, 4'h0, 2'h0, 6'h00);
    pkt(1, 2'h1, 6'h12, 0, 16'h0000, 4'h0, 2'h1, 6'h12);
    wr(8'h72, 8'h1B);
    pkt(1, 2'h1, 6'h12, 0, 16'h0000, 4'h0, 2'h2, 6'h12);
    pkt(1, 2'h3, 6'h1E, 0, 16'h0000, 4'h0, 2'h0, 6'h1E);
    wr(8'h72, 8'hE4);
  endtask
  task t_errors;
    wr(8'h6D, 8'h04);
    pkt(0, 2'h0, 6'h12, 0, 16'h0000, 4'h8, 2'h0, 6'h12);
    pkt(0, 2'h0, 6'h12, 0, 16'h0000, 4'h4, 2'h0, 6'h12);
    pkt(0, 2'h0, 6'h12, 0, 16'h0000, 4'h2, 2'h0, 6'h12);
    pkt(1, 2'h0, 6'h12, 0, 16'h0000, 4'h1, 2'h0, 6'h12);
    wr(8'h6D, 8'h3C);
    pkt(1, 2'h0, 6'h12, 0, 16'h0000, 4'h8, 2'h0, 6'h12);
    pkt(1, 2'h0, 6'h12, 0, 16'h0000, 4'h4, 2'h0, 6'h12);
    pkt(1, 2'h0, 6'h12, 0, 16'h0000, 4'h2, 2'h0, 6'h12);
    wr(8'h6D, 8'h84);
    pkt(0, 2'h0, 6'h00, 1, 16'h0002, 4'h0, 2'h0, 6'h00);
    pkt(0, 2'h0, 6'h12, 0, 16'h0001, 4'h0, 2'h0, 6'h12);
    pkt(1, 2'h0, 6'h00, 1, 16'h0001, 4'h0, 2'h0, 6'h00);
    pkt(1, 2'h0, 6'h12, 0, 16'h0000, 4'h0, 2'h0, 6'h12);
  endtask
  task t_raw;
    wr(8'h6D, 8'h0F);
    pkt(0, 2'h3, 6'h01, 0, 16'h0000, 4'h1, 2'h0, 6'h2B);
    pkt(1, 2'h3, 6'h01, 0, 16'h0000, 4'h8, 2'h0, 6'h2B);
    wr(8'h70, 8'hB5);
    pkt(1, 2'h3, 6'h01, 0, 16'h0000, 4'h0, 2'h2, 6'h35);
    wr(8'h6D, 8'h05);
    pkt(1, 2'h3, 6'h01, 0, 16'h0000, 4'h1, 2'h0, 6'h2C);
    wr(8'h71, 8'h7F);
    wr(8'h6D, 8'h06);
    pkt(1, 2'h3, 6'h01, 0, 16'h0000, 4'h0, 2'h1, 6'h3F);
  endtask
  task t_slots;
    {localGpio, cameraSyncPulse} = {8'h08, 1'b1};
    wr(8'h6E, 8'h9A);
    wr(8'h6F, 8'h83);
    repeat (3) @(posedge mclk);
    #1 chk(returnSlots_ff, 8'h07);
    {localGpio, cameraSyncPulse} = {8'hF7, 1'b0};
    repeat (3) @(posedge mclk);
    #1 chk(returnSlots_ff, 8'h02);
  endtask
  task t_coax;
    chk({6'h00, cableCoax_ff}, 8'h03);
    wr(8'h6D, 8'h38);
    repeat (3) @(posedge mclk);
    #1 chk({6'h00, cableCoax_ff}, 8'h02);
  endtask
  task end_of_test;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    #1 sys_rst = 0;
    // a pin high at release also loads the strap; raise it after reset so a_strapLoad sees the rise
    repeat (3) @(posedge mclk);
    #1 powerDownBar = 1;
    repeat (3) @(posedge mclk);
    t_defaults;
    t_gate;
    t_errors;
    t_raw;
    t_port1;
    t_slots;
    t_coax;
    t_freeze;
    end_of_test;
  end
endmodule // tb_top
